/* File: rtl/vip_pkg.sv */
// Shared types and constants of the video input port
package vip_pkg;

  // ----------------------------------------
  // Parallel input formats
  // ----------------------------------------
  typedef enum logic [1:0] {
    FMT_PAR24,
    FMT_YC422_16,
    FMT_SER8_444,
    FMT_SER8_422
  } vip_fmt_e;

  // Pixel handed to the display path
  typedef struct packed {
    logic [23:0] data;
    logic eye;
    logic sof;
  } vip_pix_s;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int VS_TOUT_MS = 200;
  localparam int VS_TOUT_CYC = VS_TOUT_MS * (CLK_HZ / 1000);
  localparam int VS_CNT_W = 23;

  // ----------------------------------------
  // Phase counts and reset values
  // ----------------------------------------
  localparam logic [1:0] SER444_LAST = 2'h2;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam logic [1:0] BPP3_LAST = 2'h2;
  localparam logic [1:0] BPP2_LAST = 2'h1;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [1:0] VC_VIDEO = 2'h0;

  // ----------------------------------------
  // Packet data types
  // ----------------------------------------
  localparam logic [5:0] DT_VS_START = 6'h01;
  localparam logic [5:0] DT_RGB888 = 6'h3e;
  localparam logic [5:0] DT_RGB666L = 6'h2e;
  localparam logic [5:0] DT_RGB666P = 6'h1e;
  localparam logic [5:0] DT_RGB565 = 6'h0e;
  localparam logic [5:0] DT_YC422 = 6'h2c;
  localparam logic [5:0] DT_DCS_S0 = 6'h05;
  localparam logic [5:0] DT_DCS_S1 = 6'h15;
  localparam logic [5:0] DT_DCS_L = 6'h39;
  localparam logic [5:0] DT_GEN_L = 6'h29;

  // Header parity masks, one per check bit
  localparam logic [23:0] ECC_M0 = 24'hf12cb7;
  localparam logic [23:0] ECC_M1 = 24'hf2555b;
  localparam logic [23:0] ECC_M2 = 24'h749a6d;
  localparam logic [23:0] ECC_M3 = 24'hb8e38e;
  localparam logic [23:0] ECC_M4 = 24'hdf03f0;
  localparam logic [23:0] ECC_M5 = 24'heffc00;

  // Check bits of a packet header
  function automatic logic [5:0] ecc6(input logic [23:0] h);
    ecc6 = {^(h & ECC_M5), ^(h & ECC_M4), ^(h & ECC_M3),
            ^(h & ECC_M2), ^(h & ECC_M1), ^(h & ECC_M0)};
  endfunction

  // Long packets carry a word count and payload
  function automatic logic is_long(input logic [5:0] dt);
    is_long = dt[3:0] > 4'h8;
  endfunction

endpackage

/* File: rtl/vip_sync.sv */
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module vip_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clock_i,
  input wire logic ce_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  // Only the second stage reads the first
  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end

  assign q_o = s2_r;

endmodule

/* File: rtl/vip_crc16.sv */
// Payload checksum, reflected CCITT, byte at a time
`timescale 1ns/1ps
module vip_crc16 (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Control and data
  input wire logic init_i,
  input wire logic feed_i,
  input wire logic [7:0] byte_i,
  output logic [15:0] crc_o
);

  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // Shift in one byte, least significant bit first
  always_comb begin
    crc_nxt = crc_r;
    if (init_i) begin
      crc_nxt = vip_pkg::CRC_INIT;
    end else if (feed_i) begin
      for (int i = 0; i < 8; i++) begin
        if (crc_nxt[0] ^ byte_i[i]) begin
          crc_nxt = (crc_nxt >> 1) ^ vip_pkg::CRC_POLY;
        end else begin
          crc_nxt = crc_nxt >> 1;
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      crc_r <= vip_pkg::CRC_INIT;
    end else if (ce_i) begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_o = crc_r;

endmodule

/* File: rtl/vip_top.sv */
// Video input port: parallel pixel bus and serial packet receiver
`timescale 1ns/1ps

module vip_top #(
  parameter int unsigned VS_TOUT_CYC = vip_pkg::VS_TOUT_CYC
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Configuration
  input wire logic src_dsi_i,
  input wire vip_pkg::vip_fmt_e fmt_i,
  input wire logic mask_active_low_i,
  input wire logic ecc_check_en_i,
  input wire logic err_clr_i,
  input wire logic boot_done_i,
  input wire logic init_done_i,
  // Parallel pins
  input wire logic pclk_i,
  input wire logic vsync_i,
  input wire logic [23:0] parallel_pixel_bus_i,
  input wire logic pixel_valid_in_i,
  input wire logic frame_update_mask_i,
  input wire logic eye_select_in_i,
  // Lane select pins
  input wire logic [1:0] lane_sel_i,
  // Receiver byte stream
  input wire logic dsi_hs_i,
  input wire logic dsi_byte_valid_i,
  input wire logic [7:0] dsi_byte_i,
  // Display side
  output vip_pkg::vip_pix_s pix_o,
  output logic pix_valid_o,
  output logic frame_start_o,
  output logic display_hold_o,
  output logic seq_run_o,
  output logic led_en_o,
  // Status
  output logic [3:0] lane_en_o,
  output logic hdr_err_o,
  output logic crc_err_o,
  output logic cmd_err_o,
  // Host interrupt pin
  output logic host_irq_o,
  output logic host_irq_oe_o
);

  typedef enum logic [1:0] {ST_HDR, ST_PAY, ST_CRC} vip_st_e;

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [30:0] pin_s;
  logic pclk_s;
  logic vs_s;
  logic vld_s;
  logic msk_s;
  logic eye_s;
  logic [23:0] pd_s;
  logic [1:0] lsel_s;

  vip_sync #(.W(31)) u_sync (
    .clock_i(clock_i),
    .ce_i(ce_i),
    .d_i({lane_sel_i, eye_select_in_i, frame_update_mask_i, pixel_valid_in_i,
          vsync_i, pclk_i, parallel_pixel_bus_i}),
    .q_o(pin_s)
  );

  assign {lsel_s, eye_s, msk_s, vld_s, vs_s, pclk_s, pd_s} = pin_s;

  // ----------------------------------------
  // Start-up and host interrupt
  // ----------------------------------------
  logic irq_r, irq_nxt, irq_oe_r, irq_oe_nxt, ready;
  logic rel_r, rel_nxt;
  logic [3:0] lane_r, lane_nxt;

  assign ready = irq_oe_r & ~irq_r;

  // Released after boot, falls once initialisation completes
  always_comb begin
    irq_oe_nxt = irq_oe_r | boot_done_i;
    irq_nxt = irq_r & ~(irq_oe_r & init_done_i);
    rel_nxt = 1'b1;
    lane_nxt = lane_r;
    if (!rel_r) begin
      case (lsel_s)
        2'h0: lane_nxt = 4'h1;
        2'h1: lane_nxt = 4'h3;
        2'h2: lane_nxt = 4'h7;
        default: lane_nxt = 4'hf;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      irq_r <= 1'b1;
      irq_oe_r <= 1'b0;
      rel_r <= 1'b0;
      lane_r <= 4'h1;
    end else if (ce_i) begin
      irq_r <= irq_nxt;
      irq_oe_r <= irq_oe_nxt;
      rel_r <= rel_nxt;
      lane_r <= lane_nxt;
    end
  end

  // ----------------------------------------
  // Parallel path
  // ----------------------------------------
  logic pclk_d_r, vs_d_r, vld_d_r, mfrm_r, efrm_r, pend_v_r;
  logic pclk_d_nxt, vs_d_nxt, vld_d_nxt, mfrm_nxt, efrm_nxt, pend_v_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [7:0] c0_r, c0_nxt, c1_r, c1_nxt, cr_r, cr_nxt;
  logic [23:0] pend_r, pend_nxt;
  localparam int VS_CNT_W_L = vip_pkg::VS_CNT_W;
  logic [VS_CNT_W_L-1:0] vsc_r, vsc_nxt;
  logic run_r, run_nxt;
  logic p_ev, p_pix, vs_rise, p_fs;
  logic [23:0] p_dat;

  // Pixel clock rising edge while valid
  assign p_ev = pclk_s & ~pclk_d_r & vld_s & ready & ~src_dsi_i;
  assign vs_rise = vs_s & ~vs_d_r;
  assign p_fs = vs_rise & ready & ~src_dsi_i;

  always_comb begin
    pclk_d_nxt = pclk_s;
    vs_d_nxt = vs_s;
    mfrm_nxt = mfrm_r;
    efrm_nxt = efrm_r;
    ph_nxt = ph_r;
    c0_nxt = c0_r;
    c1_nxt = c1_r;
    cr_nxt = cr_r;
    pend_nxt = pend_r;
    pend_v_nxt = 1'b0;
    p_pix = pend_v_r;
    p_dat = pend_r;
    // Frame boundary: mask and eye are taken at vertical sync
    if (vs_rise) begin
      mfrm_nxt = msk_s ^ mask_active_low_i;
      efrm_nxt = eye_s;
      ph_nxt = 2'h0;
    end else if (!vld_s) begin
      ph_nxt = 2'h0;
    end else if (p_ev) begin
      ph_nxt = ph_r + 2'h1;
      case (fmt_i)
        vip_pkg::FMT_YC422_16: begin
          if (ph_r[0] == 1'b0) begin
            c0_nxt = pd_s[15:8];
            c1_nxt = pd_s[7:0];
          end else begin
            p_pix = 1'b1;
            p_dat = {c0_r, c1_r, pd_s[7:0]};
            pend_nxt = {pd_s[15:8], c1_r, pd_s[7:0]};
            pend_v_nxt = 1'b1;
          end
        end
        vip_pkg::FMT_SER8_444: begin
          if (ph_r == 2'h0) begin
            c0_nxt = pd_s[7:0];
          end else if (ph_r == 2'h1) begin
            c1_nxt = pd_s[7:0];
          end else begin
            p_pix = 1'b1;
            p_dat = {c0_r, c1_r, pd_s[7:0]};
          end
          if (ph_r == vip_pkg::SER444_LAST) begin
            ph_nxt = 2'h0;
          end
        end
        vip_pkg::FMT_SER8_422: begin
          if (ph_r == 2'h0) begin
            c1_nxt = pd_s[7:0];
          end else if (ph_r == 2'h2) begin
            cr_nxt = pd_s[7:0];
          end else begin
            p_pix = 1'b1;
            p_dat = {pd_s[7:0], c1_r, (ph_r == 2'h1) ? cr_r : pd_s[7:0]};
            if (ph_r == 2'h3) begin
              p_dat = {pd_s[7:0], c1_r, cr_r};
            end
          end
        end
        default: begin
          p_pix = 1'b1;
          p_dat = pd_s;
          ph_nxt = 2'h0;
        end
      endcase
    end
    vld_d_nxt = p_pix | (vld_s & vld_d_r);
    // Vertical sync watchdog
    if (vs_s != vs_d_r) begin
      vsc_nxt = '0;
    end else if (vsc_r != VS_TOUT_CYC[VS_CNT_W_L-1:0]) begin
      vsc_nxt = vsc_r + 1'b1;
    end else begin
      vsc_nxt = vsc_r;
    end
    run_nxt = ready & (src_dsi_i | (vsc_r != VS_TOUT_CYC[VS_CNT_W_L-1:0]));
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pclk_d_r <= 1'b0;
      vs_d_r <= 1'b0;
      vld_d_r <= 1'b0;
      mfrm_r <= 1'b0;
      efrm_r <= 1'b0;
      pend_v_r <= 1'b0;
      ph_r <= 2'h0;
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      cr_r <= 8'h00;
      pend_r <= 24'h000000;
      vsc_r <= '0;
      run_r <= 1'b0;
    end else if (ce_i) begin
      pclk_d_r <= pclk_d_nxt;
      vs_d_r <= vs_d_nxt;
      vld_d_r <= vld_d_nxt;
      mfrm_r <= mfrm_nxt;
      efrm_r <= efrm_nxt;
      pend_v_r <= pend_v_nxt;
      ph_r <= ph_nxt;
      c0_r <= c0_nxt;
      c1_r <= c1_nxt;
      cr_r <= cr_nxt;
      pend_r <= pend_nxt;
      vsc_r <= vsc_nxt;
      run_r <= run_nxt;
    end
  end

  // ----------------------------------------
  // Packet receiver
  // ----------------------------------------
  vip_st_e st_r, st_nxt;
  logic [1:0] hc_r, hc_nxt, bc_r, bc_nxt;
  logic [23:0] hdr_r, hdr_nxt;
  logic [15:0] wc_r, wc_nxt, pb_r, pb_nxt, crc_v;
  logic [7:0] clo_r, clo_nxt;
  logic [5:0] dt_r, dt_nxt;
  logic keep_r, keep_nxt, clo_v_r, clo_v_nxt;
  logic d_in, d_pix, d_fs, e_hdr, e_crc, e_cmd, crc_init, crc_feed;
  logic [23:0] d_dat;
  logic [31:0] full;

  assign d_in = dsi_byte_valid_i & dsi_hs_i & ready & src_dsi_i;
  assign full = {dsi_byte_i, hdr_r};

  vip_crc16 u_crc (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .init_i(crc_init),
    .feed_i(crc_feed),
    .byte_i(dsi_byte_i),
    .crc_o(crc_v)
  );

  always_comb begin
    st_nxt = st_r;
    hc_nxt = hc_r;
    bc_nxt = bc_r;
    hdr_nxt = hdr_r;
    wc_nxt = wc_r;
    pb_nxt = pb_r;
    clo_nxt = clo_r;
    clo_v_nxt = clo_v_r;
    dt_nxt = dt_r;
    keep_nxt = keep_r;
    d_pix = 1'b0;
    d_fs = 1'b0;
    d_dat = 24'h000000;
    e_hdr = 1'b0;
    e_crc = 1'b0;
    e_cmd = 1'b0;
    crc_init = 1'b0;
    crc_feed = 1'b0;
    if (!dsi_hs_i) begin
      // End of a transmission restarts header search
      st_nxt = ST_HDR;
      hc_nxt = 2'h0;
    end else if (d_in) begin
      case (st_r)
        ST_HDR: begin
          hdr_nxt = full[31:8];
          hc_nxt = hc_r + 2'h1;
          if (hc_r == vip_pkg::HDR_LAST) begin
            dt_nxt = full[5:0];
            wc_nxt = full[23:8];
            bc_nxt = 2'h0;
            clo_v_nxt = 1'b0;
            crc_init = 1'b1;
            keep_nxt = full[7:6] == vip_pkg::VC_VIDEO;
            if (ecc_check_en_i && vip_pkg::ecc6(full[23:0]) != full[29:24]) begin
              e_hdr = 1'b1;
            end else begin
              if (full[5:0] == vip_pkg::DT_DCS_S0 || full[5:0] == vip_pkg::DT_DCS_S1 ||
                  full[5:0] == vip_pkg::DT_DCS_L || full[5:0] == vip_pkg::DT_GEN_L) begin
                e_cmd = 1'b1;
                keep_nxt = 1'b0;
              end
              if (full[7:6] == vip_pkg::VC_VIDEO && full[5:0] == vip_pkg::DT_VS_START) begin
                d_fs = 1'b1;
              end
              if (vip_pkg::is_long(full[5:0])) begin
                st_nxt = (full[23:8] == 16'h0000) ? ST_CRC : ST_PAY;
              end
            end
          end
        end
        ST_PAY: begin
          crc_feed = 1'b1;
          wc_nxt = wc_r - 16'h0001;
          bc_nxt = bc_r + 2'h1;
          pb_nxt = {dsi_byte_i, pb_r[15:8]};
          case (dt_r)
            vip_pkg::DT_RGB888, vip_pkg::DT_RGB666L, vip_pkg::DT_RGB666P: begin
              if (bc_r == vip_pkg::BPP3_LAST) begin
                bc_nxt = 2'h0;
                d_pix = keep_r;
                d_dat = {pb_r[7:0], pb_r[15:8], dsi_byte_i};
              end
            end
            vip_pkg::DT_RGB565: begin
              if (bc_r == vip_pkg::BPP2_LAST) begin
                bc_nxt = 2'h0;
                d_pix = keep_r;
                d_dat = {dsi_byte_i[7:3], 3'h0, dsi_byte_i[2:0], pb_r[15:13], 2'h0, pb_r[12:8], 3'h0};
              end
            end
            vip_pkg::DT_YC422: begin
              if (bc_r == vip_pkg::BPP2_LAST) begin
                bc_nxt = 2'h0;
                d_pix = keep_r;
                d_dat = {dsi_byte_i, pb_r[15:8], 8'h00};
              end
            end
            default: bc_nxt = 2'h0;
          endcase
          if (wc_r == 16'h0001) begin
            st_nxt = ST_CRC;
          end
        end
        ST_CRC: begin
          clo_nxt = dsi_byte_i;
          clo_v_nxt = 1'b1;
          if (clo_v_r) begin
            // Checked and reported, payload left as received
            e_crc = {dsi_byte_i, clo_r} != crc_v;
            st_nxt = ST_HDR;
            hc_nxt = 2'h0;
          end
        end
        default: st_nxt = ST_HDR;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      st_r <= ST_HDR;
      hc_r <= 2'h0;
      bc_r <= 2'h0;
      hdr_r <= 24'h000000;
      wc_r <= 16'h0000;
      pb_r <= 16'h0000;
      clo_r <= 8'h00;
      clo_v_r <= 1'b0;
      dt_r <= 6'h00;
      keep_r <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      hc_r <= hc_nxt;
      bc_r <= bc_nxt;
      hdr_r <= hdr_nxt;
      wc_r <= wc_nxt;
      pb_r <= pb_nxt;
      clo_r <= clo_nxt;
      clo_v_r <= clo_v_nxt;
      dt_r <= dt_nxt;
      keep_r <= keep_nxt;
    end
  end

  // ----------------------------------------
  // Outputs and sticky errors
  // ----------------------------------------
  vip_pkg::vip_pix_s pix_r, pix_nxt;
  logic pv_r, pv_nxt, fs_r, fs_nxt, hold_r, hold_nxt;
  logic he_r, he_nxt, ce_r, ce_nxt, me_r, me_nxt;

  always_comb begin
    pix_nxt = pix_r;
    pix_nxt.sof = 1'b0;
    pv_nxt = 1'b0;
    fs_nxt = src_dsi_i ? d_fs : p_fs;
    hold_nxt = src_dsi_i ? 1'b0 : mfrm_r;
    if (src_dsi_i && d_pix) begin
      pv_nxt = 1'b1;
      pix_nxt = '{data: d_dat, eye: eye_s, sof: 1'b0};
    end else if (!src_dsi_i && p_pix && !mfrm_r) begin
      pv_nxt = 1'b1;
      pix_nxt = '{data: p_dat, eye: efrm_r, sof: ~vld_d_r};
    end
    // Set wins over clear
    he_nxt = e_hdr | (he_r & ~err_clr_i);
    ce_nxt = e_crc | (ce_r & ~err_clr_i);
    me_nxt = e_cmd | (me_r & ~err_clr_i);
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pix_r <= '0;
      pv_r <= 1'b0;
      fs_r <= 1'b0;
      hold_r <= 1'b0;
      he_r <= 1'b0;
      ce_r <= 1'b0;
      me_r <= 1'b0;
    end else if (ce_i) begin
      pix_r <= pix_nxt;
      pv_r <= pv_nxt;
      fs_r <= fs_nxt;
      hold_r <= hold_nxt;
      he_r <= he_nxt;
      ce_r <= ce_nxt;
      me_r <= me_nxt;
    end
  end

  assign pix_o = pix_r;
  assign pix_valid_o = pv_r;
  assign frame_start_o = fs_r;
  assign display_hold_o = hold_r;
  assign seq_run_o = run_r;
  assign led_en_o = run_r;
  assign lane_en_o = lane_r;
  assign hdr_err_o = he_r;
  assign crc_err_o = ce_r;
  assign cmd_err_o = me_r;
  assign host_irq_o = irq_r;
  assign host_irq_oe_o = irq_oe_r;

endmodule

/* File: tb/vip_monitor.sv */
// Checker of the video input port outputs
`timescale 1ns/1ps
module vip_monitor #(
  parameter int unsigned VS_TOUT_CYC = 200
) (
  // Clock, reset, configuration
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic src_dsi_i,
  input wire logic ecc_check_en_i,
  input wire logic err_clr_i,
  input wire logic vsync_i,
  input wire logic dsi_byte_valid_i,
  // Watched outputs
  input wire logic pix_valid_o,
  input wire logic frame_start_o,
  input wire logic display_hold_o,
  input wire logic seq_run_o,
  input wire logic led_en_o,
  input wire logic [3:0] lane_en_o,
  input wire logic hdr_err_o,
  input wire logic crc_err_o,
  input wire logic host_irq_o,
  input wire logic host_irq_oe_o
);
  logic vs_r, vs_nxt;
  logic [31:0] quiet_r, quiet_nxt;
  // Cycles since the sync pin last moved
  always_comb begin
    vs_nxt = vsync_i;
    quiet_nxt = (!rstn_i || vsync_i != vs_r) ? 32'h0 : quiet_r + {31'h0, quiet_r < 32'hffff};
  end
  always_ff @(posedge clock_i) begin
    vs_r <= vs_nxt;
    quiet_r <= quiet_nxt;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  AST_LANES: assert property ($past(rstn_i, 2) |-> $stable(lane_en_o) && lane_en_o inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("lane enables moved");
  AST_READY: assert property (pix_valid_o |-> host_irq_oe_o && !host_irq_o)
    else $error("pixel before init done");
  AST_IRQ_FALL: assert property ($fell(host_irq_o) |-> host_irq_oe_o)
    else $error("irq fell undriven");
  AST_MASKED: assert property (display_hold_o && !src_dsi_i |-> !pix_valid_o)
    else $error("pixel of masked frame");
  AST_LED: assert property (led_en_o == seq_run_o)
    else $error("leds differ from sequencer");
  AST_VS_LOSS: assert property (quiet_r > VS_TOUT_CYC + 8 && !src_dsi_i |-> !led_en_o)
    else $error("leds on without sync");
  AST_CRC_HOLD: assert property (crc_err_o && !err_clr_i |=> crc_err_o)
    else $error("checksum flag lost");
  AST_HDR_OFF: assert property ($rose(hdr_err_o) |-> $past(ecc_check_en_i))
    else $error("header error while check off");
  AST_FRAME_PULSE: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame pulse too long");
  AST_DSI_PIX: assert property (pix_valid_o && src_dsi_i |-> $past(dsi_byte_valid_i))
    else $error("packet pixel without byte");
  cover property (pix_valid_o && !src_dsi_i);
  cover property ($rose(crc_err_o));
  cover property ($fell(led_en_o));
endmodule

/* File: tb/vip_src_model.sv */
// Model of the video source on the parallel pins
`timescale 1ns/1ps
module vip_src_model (
  // Clock
  input wire logic clock_i,
  // Parallel pins
  output logic pclk_o = 1'h0,
  output logic vsync_o = 1'h0,
  output logic [23:0] data_o = 24'h0,
  output logic valid_o = 1'h0,
  output logic mask_o = 1'h0,
  output logic eye_o = 1'h0
);
  // New frame: mask and eye move only in blanking, then sync rises
  task automatic frame(input logic m, input logic e);
    @(posedge clock_i);
    vsync_o <= 1'h0;
    mask_o <= m;
    eye_o <= e;
    repeat (4) @(posedge clock_i);
    vsync_o <= 1'h1;
    repeat (4) @(posedge clock_i);
  endtask
  // One pixel clock of 400 ns, data set up before the rise
  task automatic word(input logic [23:0] d);
    @(posedge clock_i);
    data_o <= d;
    valid_o <= 1'h1;
    @(posedge clock_i);
    pclk_o <= 1'h1;
    repeat (4) @(posedge clock_i);
    pclk_o <= 1'h0;
    repeat (2) @(posedge clock_i);
  endtask
  // Line end: valid drops, data stops holding, pixel clock stands
  task automatic line_end();
    @(posedge clock_i);
    valid_o <= 1'h0;
    data_o <= ~data_o;
  endtask
endmodule

/* File: tb/vip_top_tb.sv */
// Testbench of the video input port
`timescale 1ns/1ps
module vip_top_tb;
  localparam int unsigned TOUT = 200;
  logic clock_i = 1'h0, rstn_i = 1'h0, src_dsi_i = 1'h0, mask_active_low_i = 1'h0, ecc_check_en_i = 1'h1;
  logic err_clr_i = 1'h0, boot_done_i = 1'h0, init_done_i = 1'h0, dsi_hs_i = 1'h0, dsi_byte_valid_i = 1'h0;
  vip_pkg::vip_fmt_e fmt_i = vip_pkg::FMT_PAR24;
  logic [1:0] lane_sel_i = 2'h2;
  logic [7:0] dsi_byte_i = 8'h0;
  logic pclk, vsync, valid, mask, eye, pix_valid_o, frame_start_o, display_hold_o, seq_run_o, led_en_o;
  logic hdr_err_o, crc_err_o, cmd_err_o, host_irq_o, host_irq_oe_o;
  logic [23:0] parallel_pixel_bus;
  logic [3:0] lane_en_o;
  vip_pkg::vip_pix_s pix_o;
  vip_pkg::vip_pix_s pix_q[$];
  int failures = 0, num_checks = 0, frames = 0;
  wire irq_pin = host_irq_oe_o ? host_irq_o : 1'h1;
  always #25 clock_i = ~clock_i;
  vip_src_model SRC (.clock_i(clock_i), .pclk_o(pclk), .vsync_o(vsync), .data_o(parallel_pixel_bus), .valid_o(valid),
    .mask_o(mask), .eye_o(eye));
  vip_top #(.VS_TOUT_CYC(TOUT)) DUT (.clock_i(clock_i), .rstn_i(rstn_i), .ce_i(1'h1), .src_dsi_i(src_dsi_i),
    .fmt_i(fmt_i), .mask_active_low_i(mask_active_low_i), .ecc_check_en_i(ecc_check_en_i),
    .err_clr_i(err_clr_i), .boot_done_i(boot_done_i), .init_done_i(init_done_i), .pclk_i(pclk),
    .vsync_i(vsync), .parallel_pixel_bus_i(parallel_pixel_bus), .pixel_valid_in_i(valid), .frame_update_mask_i(mask),
    .eye_select_in_i(eye), .lane_sel_i(lane_sel_i), .dsi_hs_i(dsi_hs_i), .dsi_byte_valid_i(dsi_byte_valid_i),
    .dsi_byte_i(dsi_byte_i), .pix_o(pix_o), .pix_valid_o(pix_valid_o), .frame_start_o(frame_start_o),
    .display_hold_o(display_hold_o), .seq_run_o(seq_run_o), .led_en_o(led_en_o), .lane_en_o(lane_en_o),
    .hdr_err_o(hdr_err_o), .crc_err_o(crc_err_o), .cmd_err_o(cmd_err_o), .host_irq_o(host_irq_o),
    .host_irq_oe_o(host_irq_oe_o));
  // Collect pixels and frame pulses
  always @(posedge clock_i) begin
    if (pix_valid_o === 1'h1) pix_q.push_back(pix_o);
    if (frame_start_o === 1'h1) frames++;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for n pixels; zero means none may come
  task automatic wait_pix(input int n);
    for (int i = 0; i < 40 && !(n > 0 && pix_q.size() >= n); i++) @(posedge clock_i);
    chk("pixel count", n, pix_q.size());
    if (pix_q.size() < n) complete_run();
  endtask
  task automatic t_start();
    repeat (2) @(posedge clock_i);
    lane_sel_i <= 2'h0;
    boot_done_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    chk("irq pin", 24'h1, irq_pin);
    init_done_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    chk("irq pin", 24'h0, irq_pin);
    chk("lanes", 24'h7, lane_en_o);
  endtask
  task automatic t_fmt(input vip_pkg::vip_fmt_e f, input logic [23:0] w[4], input int nw, input int np,
                       input logic [15:0] first_hi, input logic [23:0] last, input logic e);
    fmt_i <= f;
    pix_q.delete();
    frames = 0;
    SRC.frame(1'h0, e);
    for (int i = 0; i < nw; i++) SRC.word(w[i]);
    SRC.line_end();
    wait_pix(np);
    chk("frames", 24'h1, frames);
    chk("eye", e, pix_q[0].eye);
    chk("line start", 24'h1, pix_q[0].sof);
    chk("first pixel", first_hi, pix_q[0].data[23:8]);
    chk("last pixel", last, pix_q[np - 1].data);
  endtask
  task automatic t_mask(input logic pin, input logic low, input logic [23:0] hold);
    mask_active_low_i <= low;
    pix_q.delete();
    SRC.frame(pin, 1'h0);
    SRC.word(24'h123456);
    SRC.line_end();
    chk("hold", hold, display_hold_o);
    wait_pix(hold == 24'h1 ? 0 : 1);
  endtask
  function automatic logic [5:0] hdr_chk(input logic [23:0] h);
    return {^(h & vip_pkg::ECC_M5), ^(h & vip_pkg::ECC_M4), ^(h & vip_pkg::ECC_M3),
            ^(h & vip_pkg::ECC_M2), ^(h & vip_pkg::ECC_M1), ^(h & vip_pkg::ECC_M0)};
  endfunction
  task automatic put(input logic [7:0] b);
    @(posedge clock_i);
    dsi_hs_i <= 1'h1;
    dsi_byte_valid_i <= 1'h1;
    dsi_byte_i <= b;
  endtask
  // Packet; bad[0] spoils the header check, bad[1] the checksum
  task automatic pkt(input logic [7:0] di, input logic [15:0] wc, input logic [23:0] pl, input logic [1:0] bad);
    logic [15:0] c;
    c = vip_pkg::CRC_INIT;
    put(di);
    put(wc[7:0]);
    put(wc[15:8]);
    put({2'h0, hdr_chk({wc, di})} ^ {7'h0, bad[0]});
    if (di[3:0] > 4'h8) begin
      for (int i = 0; i < wc; i++) begin
        put(pl[23 - 8 * i -: 8]);
        for (int j = 0; j < 8; j++) c = (c[0] ^ pl[16 - 8 * i + j]) ? ((c >> 1) ^ vip_pkg::CRC_POLY) : (c >> 1);
      end
      c = c ^ {15'h0, bad[1]};
      put(c[7:0]);
      put(c[15:8]);
    end
    @(posedge clock_i);
    dsi_hs_i <= 1'h0;
    dsi_byte_valid_i <= 1'h0;
    repeat (3) @(posedge clock_i);
  endtask
  task automatic clr();
    err_clr_i <= 1'h1;
    @(posedge clock_i);
    err_clr_i <= 1'h0;
  endtask
  task automatic t_dsi();
    logic [5:0] dt3[3] = '{vip_pkg::DT_RGB888, vip_pkg::DT_RGB666L, vip_pkg::DT_RGB666P};
    logic [5:0] cmd[4] = '{vip_pkg::DT_DCS_S0, vip_pkg::DT_DCS_S1, vip_pkg::DT_DCS_L, vip_pkg::DT_GEN_L};
    @(posedge clock_i);
    src_dsi_i <= 1'h1;
    pix_q.delete();
    frames = 0;
    pkt({2'h0, vip_pkg::DT_VS_START}, 16'h0, 24'h0, 2'h0);
    chk("frames", 24'h1, frames);
    foreach (dt3[k]) pkt({2'h0, dt3[k]}, 16'h3, 24'hc0ffee, 2'h0);
    pkt({2'h0, vip_pkg::DT_RGB565}, 16'h2, 24'hf81f00, 2'h0);
    pkt({2'h0, vip_pkg::DT_YC422}, 16'h2, 24'h1234aa, 2'h0);
    pkt({2'h1, vip_pkg::DT_RGB888}, 16'h3, 24'h777777, 2'h0);
    wait_pix(5);
    for (int k = 0; k < 3; k++) chk("three byte pixel", 24'hc0ffee, pix_q[k].data);
    chk("yc422 pixel", 24'h341200, pix_q[4].data);
    chk("crc flag", 24'h0, crc_err_o);
    pkt({2'h0, vip_pkg::DT_RGB888}, 16'h3, 24'h010203, 2'h2);
    repeat (6) @(posedge clock_i);
    chk("crc flag", 24'h1, crc_err_o);
    chk("uncorrected", 24'h010203, pix_q[$].data);
    clr();
    pkt({2'h0, vip_pkg::DT_VS_START}, 16'h0, 24'h0, 2'h1);
    chk("hdr flag", 24'h1, hdr_err_o);
    chk("crc flag", 24'h0, crc_err_o);
    chk("frames", 24'h1, frames);
    ecc_check_en_i <= 1'h0;
    clr();
    pkt({2'h0, vip_pkg::DT_VS_START}, 16'h0, 24'h0, 2'h1);
    chk("hdr flag", 24'h0, hdr_err_o);
    chk("frames", 24'h2, frames);
    foreach (cmd[k]) begin
      clr();
      pkt({2'h0, cmd[k]}, 16'h1, 24'h5500, 2'h0);
      chk("cmd flag", 24'h1, cmd_err_o);
    end
  endtask
  initial begin
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'h1;
    t_start();
    t_fmt(vip_pkg::FMT_PAR24, '{24'h5a3c81, 24'h0, 24'h0, 24'h0}, 1, 1, 16'h5a3c, 24'h5a3c81, 1'h1);
    t_fmt(vip_pkg::FMT_SER8_444, '{24'hee0011, 24'hee0022, 24'hee0033, 24'h0}, 3, 1, 16'h1122, 24'h112233,
          1'h0);
    t_fmt(vip_pkg::FMT_SER8_422, '{24'hee0040, 24'hee0050, 24'hee0060, 24'hee0070}, 4, 2, 16'h5040,
          24'h704060, 1'h1);
    t_fmt(vip_pkg::FMT_YC422_16, '{24'h008142, 24'h009163, 24'h0, 24'h0}, 2, 2, 16'h8142, 24'h914263,
          1'h0);
    fmt_i <= vip_pkg::FMT_PAR24;
    t_mask(1'h1, 1'h0, 24'h1);
    t_mask(1'h0, 1'h1, 24'h1);
    t_mask(1'h0, 1'h0, 24'h0);
    repeat (TOUT + 20) @(posedge clock_i);
    chk("sequencer", 24'h0, seq_run_o);
    chk("leds", 24'h0, led_en_o);
    SRC.frame(1'h0, 1'h0);
    chk("leds", 24'h1, led_en_o);
    t_dsi();
    complete_run();
  end
endmodule
bind vip_top vip_monitor #(.VS_TOUT_CYC(VS_TOUT_CYC)) MON (.clock_i(clock_i), .rstn_i(rstn_i),
  .src_dsi_i(src_dsi_i), .ecc_check_en_i(ecc_check_en_i), .err_clr_i(err_clr_i), .vsync_i(vsync_i),
  .dsi_byte_valid_i(dsi_byte_valid_i), .pix_valid_o(pix_valid_o), .frame_start_o(frame_start_o),
  .display_hold_o(display_hold_o), .seq_run_o(seq_run_o), .led_en_o(led_en_o), .lane_en_o(lane_en_o),
  .hdr_err_o(hdr_err_o), .crc_err_o(crc_err_o), .host_irq_o(host_irq_o), .host_irq_oe_o(host_irq_oe_o));
